// ==== logic/tims_pkg.sv ====
/*
 * package for the timer interrupt mask/status block: register offsets,
 * field positions and reset values.
 * assumes a plain word-addressed register port with byte offsets.
 */
package tims_pkg;
    localparam logic [7:0] OFF_ENABLE_MASK = 8'h18;
    localparam logic [7:0] OFF_RAW_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_MASKED_FLAGS = 8'h20;
    localparam logic [7:0] OFF_CLEAR_REG = 8'h24;
    localparam int BIT_CNTA_TIMEOUT = 0;
    localparam int BIT_CAPA_MATCH = 1;
    localparam int BIT_CAPA_EVENT = 2;
    localparam int BIT_CLOCK_EVENT = 3;
    localparam int BIT_CNTB_TIMEOUT = 8;
    localparam int BIT_CAPB_MATCH = 9;
    localparam int BIT_CAPB_EVENT = 10;
    localparam logic [10:0] IMPL_BITS = 11'h70f;
    localparam logic [10:0] MASK_RESET = 11'h000;
    localparam logic [10:0] RAW_RESET = 11'h000;
endpackage

// ==== logic/tims_irq.sv ====
/*
 * interrupt enable mask, raw flags and masked flags of the timer module.
 * assumes event inputs are one-cycle pulses synchronous to clock_i and
 * a register master that never issues read and write together.
 */
// The implementer's own choice: the plain strobed port.
module tims_irq (
    // clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // event sources, one-cycle pulses
    input wire logic cnta_timeout_i,
    input wire logic capa_match_i,
    input wire logic capa_event_i,
    input wire logic clock_event_i,
    input wire logic cntb_timeout_i,
    input wire logic capb_match_i,
    input wire logic capb_event_i,
    // controller-level interrupt
    output logic irq_o
);
    logic rst_sync1_r;
    logic rst_sync2_r;
    logic [10:0] timer_irq_enable_mask_r;
    logic [10:0] timer_irq_raw_flags_r;
    logic [10:0] events;
    logic [10:0] clear_bits;
    logic [10:0] masked;
    logic mask_wr;

    // register decode, shared by the write paths and the checks; the read mux cases on addr_i itself
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // pad an 11-bit field image to the bus word; reserved bits read zero
    function automatic logic [31:0] widen(input logic [10:0] field);
        widen = {21'h0, field};
    endfunction

    // next raw image: clear first, then set, so a same-cycle event survives
    function automatic logic [10:0] flag_next(input logic [10:0] cur, input logic [10:0] clr,
                                              input logic [10:0] set);
        flag_next = (cur & ~clr) | set;
    endfunction

    // reset released through two flops
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    // event vector in register bit order
    always_comb begin
        events = 11'h000;
        events[tims_pkg::BIT_CNTA_TIMEOUT] = cnta_timeout_i;
        events[tims_pkg::BIT_CAPA_MATCH] = capa_match_i;
        events[tims_pkg::BIT_CAPA_EVENT] = capa_event_i;
        events[tims_pkg::BIT_CLOCK_EVENT] = clock_event_i;
        events[tims_pkg::BIT_CNTB_TIMEOUT] = cntb_timeout_i;
        events[tims_pkg::BIT_CAPB_MATCH] = capb_match_i;
        events[tims_pkg::BIT_CAPB_EVENT] = capb_event_i;
    end

    assign clear_bits = (wr_i && reg_hit(addr_i, tims_pkg::OFF_CLEAR_REG)) ?
                        (wdata_i[10:0] & tims_pkg::IMPL_BITS) : 11'h000;
    assign masked = timer_irq_raw_flags_r & timer_irq_enable_mask_r;
    // mask write strobe, decoded once
    assign mask_wr = wr_i && reg_hit(addr_i, tims_pkg::OFF_ENABLE_MASK);

    // mask register; reserved bits never stored
    always_ff @(posedge clock_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            timer_irq_enable_mask_r <= tims_pkg::MASK_RESET;
        end else if (mask_wr) begin
            timer_irq_enable_mask_r <= wdata_i[10:0] & tims_pkg::IMPL_BITS;
        end
    end

    // raw flags; set wins over a same-cycle clear
    always_ff @(posedge clock_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            timer_irq_raw_flags_r <= tims_pkg::RAW_RESET;
        end else begin
            timer_irq_raw_flags_r <= flag_next(timer_irq_raw_flags_r, clear_bits, events);
        end
    end

    // read data, valid only the cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            unique case (addr_i)
                tims_pkg::OFF_ENABLE_MASK: rdata_o <= widen(timer_irq_enable_mask_r);
                tims_pkg::OFF_RAW_FLAGS: rdata_o <= widen(timer_irq_raw_flags_r);
                tims_pkg::OFF_MASKED_FLAGS: rdata_o <= widen(masked);
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // interrupt output registered to keep it glitch free
    always_ff @(posedge clock_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |masked;
        end
    end

    AST_RAW_SET: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        capb_event_i |=> timer_irq_raw_flags_r[10]) else $error("raw flag not set");
    AST_CLR: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[0] && !cnta_timeout_i) |=> !timer_irq_raw_flags_r[0])
        else $error("flag not cleared");
    AST_HOLD: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (!clear_bits[1]) |=> (timer_irq_raw_flags_r[1] || !$past(timer_irq_raw_flags_r[1])))
        else $error("flag lost");
    AST_IRQ: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (|masked) |=> irq_o) else $error("irq missing");
    AST_MASKOFF: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_enable_mask_r == 11'h000) |=> !irq_o) else $error("masked irq seen");
    AST_RD_RAW: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (rd_i && addr_i == tims_pkg::OFF_RAW_FLAGS)
        |=> rdata_o == {21'h0, $past(timer_irq_raw_flags_r)}) else $error("raw read bad");
    AST_RD_MIS: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (rd_i && addr_i == tims_pkg::OFF_MASKED_FLAGS)
        |=> rdata_o == {21'h0, $past(masked)}) else $error("masked read bad");
    AST_RSVD: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        rdata_o[31:11] == 21'h0 && rdata_o[7:4] == 4'h0) else $error("reserved set");
    AST_MASK_WR: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (wr_i && addr_i == tims_pkg::OFF_ENABLE_MASK)
        |=> timer_irq_enable_mask_r == ($past(wdata_i[10:0]) & tims_pkg::IMPL_BITS))
        else $error("mask write bad");

    // every source sets its own flag, mask never consulted
    AST_SET_CNTA: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        cnta_timeout_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CNTA_TIMEOUT])
        else $error("counter A flag not set");
    AST_SET_CAPAM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        capa_match_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CAPA_MATCH])
        else $error("capture A match flag not set");
    AST_SET_CAPAE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        capa_event_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CAPA_EVENT])
        else $error("capture A event flag not set");
    AST_SET_CLK: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        clock_event_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CLOCK_EVENT])
        else $error("clock event flag not set");
    AST_SET_CNTB: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        cntb_timeout_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CNTB_TIMEOUT])
        else $error("counter B flag not set");
    AST_SET_CAPBM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        capb_match_i |=> timer_irq_raw_flags_r[tims_pkg::BIT_CAPB_MATCH])
        else $error("capture B match flag not set");

    // a one in the clear word drops the flag unless its event repeats
    AST_CLR_CAPAM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[1] && !capa_match_i) |=> !timer_irq_raw_flags_r[1])
        else $error("capture A match flag not cleared");
    AST_CLR_CAPAE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[2] && !capa_event_i) |=> !timer_irq_raw_flags_r[2])
        else $error("capture A event flag not cleared");
    AST_CLR_CLK: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[3] && !clock_event_i) |=> !timer_irq_raw_flags_r[3])
        else $error("clock event flag not cleared");
    AST_CLR_CNTB: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[8] && !cntb_timeout_i) |=> !timer_irq_raw_flags_r[8])
        else $error("counter B flag not cleared");
    AST_CLR_CAPBM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[9] && !capb_match_i) |=> !timer_irq_raw_flags_r[9])
        else $error("capture B match flag not cleared");
    AST_CLR_CAPBE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits[10] && !capb_event_i) |=> !timer_irq_raw_flags_r[10])
        else $error("capture B event flag not cleared");

    // each enable bit follows its write data bit
    AST_MW_CNTA: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[0] == $past(wdata_i[0]))
        else $error("mask bit 0 write lost");
    AST_MW_CAPAM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[1] == $past(wdata_i[1]))
        else $error("mask bit 1 write lost");
    AST_MW_CAPAE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[2] == $past(wdata_i[2]))
        else $error("mask bit 2 write lost");
    AST_MW_CLK: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[3] == $past(wdata_i[3]))
        else $error("mask bit 3 write lost");
    AST_MW_CNTB: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[8] == $past(wdata_i[8]))
        else $error("mask bit 8 write lost");
    AST_MW_CAPBM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[9] == $past(wdata_i[9]))
        else $error("mask bit 9 write lost");
    AST_MW_CAPBE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        mask_wr |=> timer_irq_enable_mask_r[10] == $past(wdata_i[10]))
        else $error("mask bit 10 write lost");

    // an enabled, set flag reaches the interrupt one cycle later
    AST_RT_CNTA: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[0] && timer_irq_enable_mask_r[0]) |=> irq_o)
        else $error("counter A irq not routed");
    AST_RT_CAPAM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[1] && timer_irq_enable_mask_r[1]) |=> irq_o)
        else $error("capture A match irq not routed");
    AST_RT_CAPAE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[2] && timer_irq_enable_mask_r[2]) |=> irq_o)
        else $error("capture A event irq not routed");
    AST_RT_CLK: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[3] && timer_irq_enable_mask_r[3]) |=> irq_o)
        else $error("clock event irq not routed");
    AST_RT_CNTB: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[8] && timer_irq_enable_mask_r[8]) |=> irq_o)
        else $error("counter B irq not routed");
    AST_RT_CAPBM: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[9] && timer_irq_enable_mask_r[9]) |=> irq_o)
        else $error("capture B match irq not routed");
    AST_RT_CAPBE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r[10] && timer_irq_enable_mask_r[10]) |=> irq_o)
        else $error("capture B event irq not routed");

    // set beats a same-cycle clear; nothing but the clear word drops a flag
    AST_SET_WINS: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (events != 11'h000) |=> ((timer_irq_raw_flags_r & $past(events)) == $past(events)))
        else $error("event lost to clear");
    AST_CLR_ZERO: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (wr_i && reg_hit(addr_i, tims_pkg::OFF_CLEAR_REG) && wdata_i[10:0] == 11'h000)
        |=> (($past(timer_irq_raw_flags_r) & ~timer_irq_raw_flags_r) == 11'h000))
        else $error("zero clear dropped a flag");
    AST_KEEP: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits == 11'h000)
        |=> (($past(timer_irq_raw_flags_r) & ~timer_irq_raw_flags_r) == 11'h000))
        else $error("flag dropped without clear");
    AST_RAW_RO: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (wr_i && reg_hit(addr_i, tims_pkg::OFF_RAW_FLAGS))
        |=> (($past(timer_irq_raw_flags_r) & ~timer_irq_raw_flags_r) == 11'h000))
        else $error("raw flags written");

    // mask only moves on its own write; reserved bits never stored
    AST_MASK_HOLD: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        !mask_wr |=> $stable(timer_irq_enable_mask_r))
        else $error("mask changed without write");
    AST_MASK_RSVD: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_enable_mask_r & ~tims_pkg::IMPL_BITS) == 11'h000)
        else $error("reserved mask bit stored");
    AST_RAW_RSVD: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (timer_irq_raw_flags_r & ~tims_pkg::IMPL_BITS) == 11'h000)
        else $error("reserved raw bit stored");

    // read port: data only in the cycle after the strobe
    AST_RD_MASK: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (rd_i && reg_hit(addr_i, tims_pkg::OFF_ENABLE_MASK))
        |=> rdata_o == widen($past(timer_irq_enable_mask_r))) else $error("mask read bad");
    AST_RD_IDLE: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data without strobe");
    AST_RD_CLR: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (rd_i && reg_hit(addr_i, tims_pkg::OFF_CLEAR_REG)) |=> rdata_o == 32'h0000_0000)
        else $error("clear word readable");

    // interrupt and masked view track the flags
    AST_IRQ_LOW: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (masked == 11'h000) |=> !irq_o)
        else $error("irq without masked flag");
    AST_IRQ_FOLLOW: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        irq_o |-> $past(|masked))
        else $error("irq not from masked flags");
    AST_MASKED_CLR: assert property (@(posedge clock_i) disable iff (!rst_sync2_r)
        (clear_bits != 11'h000) |=> ((masked & $past(clear_bits) & ~$past(events)) == 11'h000))
        else $error("masked flag survived clear");
endmodule // tims_irq

// ==== tb/timer_interrupt_mask_status_test.sv ====
/* bench for tims_irq: a table of event and mask rows, then reset,
   reserved-bit, clear-with-zero and unmapped cases.
   assumes the clear register at its package offset, reads one cycle late. */
module timer_interrupt_mask_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [10:0] ev; logic [10:0] mask; logic irq;} tims_row_s;
    localparam logic [7:0] MK = tims_pkg::OFF_ENABLE_MASK;
    localparam logic [7:0] RW = tims_pkg::OFF_RAW_FLAGS;
    localparam logic [7:0] MS = tims_pkg::OFF_MASKED_FLAGS;
    localparam logic [7:0] CL = tims_pkg::OFF_CLEAR_REG;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [10:0] ev = 11'h000;
    logic [31:0] rdata_o;
    logic irq_o;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    // one row per source; some masks deliberately block their source
    tims_row_s rows [7] = '{'{11'h001, 11'h001, 1'b1}, '{11'h002, 11'h002, 1'b1},
        '{11'h004, 11'h70b, 1'b0}, '{11'h008, 11'h008, 1'b1}, '{11'h100, 11'h000, 1'b0},
        '{11'h200, 11'h200, 1'b1}, '{11'h400, 11'h400, 1'b1}};
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
    tims_irq i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cnta_timeout_i(ev[0]),
        .capa_match_i(ev[1]), .capa_event_i(ev[2]), .clock_event_i(ev[3]),
        .cntb_timeout_i(ev[8]), .capb_match_i(ev[9]), .capb_event_i(ev[10]), .irq_o(irq_o));
    // 125 MHz clock
    always #4 clock_i = ~clock_i;
    // hang guard, well above the roughly 150 cycles the tests need
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // single-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i); wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge clock_i); wr_i <= 1'b0;
    endtask
    // read data only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clock_i); rd_i <= 1'b1; addr_i <= a;
        @(posedge clock_i); rd_i <= 1'b0;
        @(negedge clock_i); `CHK(n, e, rdata_o)
    endtask
    task automatic pulse(input logic [10:0] b);
        @(posedge clock_i); ev <= b;
        @(posedge clock_i); ev <= 11'h000;
    endtask
    // main sequence: reset, table, awkward cases, second reset
    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(MK, 32'h0, "mask reset");
        rd(RW, 32'h0, "raw reset");
        $display("test reset done");
        foreach (rows[i]) begin
            wr(MK, {21'h0, rows[i].mask});
            pulse(rows[i].ev);
            rd(RW, {21'h0, rows[i].ev}, "raw");
            rd(MS, {21'h0, rows[i].ev & rows[i].mask}, "masked");
            `CHK("irq", rows[i].irq, irq_o)
            wr(CL, {21'h0, rows[i].ev});
            rd(MS, 32'h0, "masked cleared");
            rd(RW, 32'h0, "raw cleared");
            `CHK("irq idle", 1'b0, irq_o)
        end
        $display("test table done");
        wr(MK, 32'hffffffff);
        rd(MK, {21'h0, tims_pkg::IMPL_BITS}, "mask bits");
        wr(RW, 32'hffffffff);
        rd(RW, 32'h0, "raw read-only");
        pulse(11'h70f);
        wr(CL, 32'h0);
        rd(RW, 32'h70f, "clear zero");
        `CHK("irq all", 1'b1, irq_o)
        rd(8'h40, 32'h0, "unmapped");
        $display("test awkward done");
        // reset in mid-run must drop mask and flags
        @(posedge clock_i); rstn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(MK, 32'h0, "mask rereset");
        rd(RW, 32'h0, "raw rereset");
        `CHK("irq rereset", 1'b0, irq_o)
        $display("test second reset done");
        summarize();
    end
endmodule // timer_interrupt_mask_status_test
